// *** atl_pkg.sv ***
package atl_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LCFG = 8'h04;
  localparam logic [7:0] ADDR_LCONST = 8'h08;
  localparam logic [7:0] ADDR_BAND = 8'h0C;
  localparam logic [7:0] ADDR_LIMIT = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;

  // field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_COMP_BIT = 1;
  localparam int CTRL_GO_BIT = 2;
  localparam int LCFG_BASE_LSB = 0;
  localparam int LCFG_INC_LSB = 8;
  localparam int LCFG_DWELL_LSB = 16;
  localparam int LCONST_HIGH_LSB = 16;
  localparam int BAND_LOWER_LSB = 8;
  localparam int LIMIT_CEIL_LSB = 8;
  localparam int STAT_ABOVE_BIT = 8;
  localparam int STAT_BELOW_BIT = 9;
  localparam int STAT_DONE_BIT = 10;
  localparam int STAT_BUSY_BIT = 11;

  // reset values
  localparam logic [4:0] RST_BASE = 5'h00;
  localparam logic [1:0] RST_INC = 2'h0;
  localparam logic [1:0] RST_DWELL = 2'h0;
  localparam logic [10:0] RST_LOSS = 11'h000;
  localparam logic [7:0] RST_UPPER = 8'h00;
  localparam logic [7:0] RST_LOWER = 8'h00;
  localparam logic [7:0] RST_FLOOR = 8'h00;
  localparam logic [7:0] RST_CEILING = 8'hFF;

  // initial level is base times eight
  localparam int BASE_SHIFT = 3;
  // supply ratio is unsigned with seven fraction bits, 8'h80 is unity
  localparam int SCALE_FRAC = 7;

  typedef enum logic [1:0] {
    ATL_IDLE = 2'b00,
    ATL_LEARN_LOW = 2'b01,
    ATL_LEARN_HIGH = 2'b11
  } atl_state_e;

  // increment codes 00,01,10,11 give 128,16,32,64; all powers of two
  function automatic logic [2:0] incShift(input logic [1:0] code);
    case (code)
      2'h0: incShift = 3'h7;
      2'h1: incShift = 3'h4;
      2'h2: incShift = 3'h5;
      default: incShift = 3'h6;
    endcase
  endfunction : incShift

  // dwell codes give 8,16,24,32 half-cycles
  function automatic logic [5:0] dwellCount(input logic [1:0] code);
    dwellCount = {1'b0, code, 3'h0} + 6'h08;
  endfunction : dwellCount

endpackage : atl_pkg

// *** atl_scale.sv ***
`timescale 1ns/100ps
module atl_scale #(
  parameter int W = 8
) (
  input wire logic [W-1:0] value,
  input wire logic [7:0] ratio,
  input wire logic enable,
  output logic [W-1:0] scaled
);
  logic [W+7:0] prod;
  logic [W+7:0] shifted;

  always_comb
  begin
    prod = value * ratio;
    shifted = prod >> atl_pkg::SCALE_FRAC;
    if (!enable)
      scaled = value;
    else if (shifted > (W+8)'({W{1'b1}}))
      scaled = {W{1'b1}};
    else
      scaled = shifted[W-1:0];
  end
endmodule : atl_scale

// *** atl_interp.sv ***
`timescale 1ns/100ps
module atl_interp (
  input wire logic [10:0] lossLow,
  input wire logic [10:0] lossHigh,
  input wire logic [7:0] level,
  input wire logic [7:0] initLevel,
  input wire logic [2:0] shift,
  output logic [10:0] estimate
);
  logic signed [11:0] diff;
  logic signed [8:0] dLevel;
  logic signed [20:0] prod;
  logic signed [20:0] sum;

  // straight line through the two learned points; step is a power of two
  always_comb
  begin
    diff = $signed({1'b0, lossHigh}) - $signed({1'b0, lossLow});
    dLevel = $signed({1'b0, level}) - $signed({1'b0, initLevel});
    prod = (21'(diff) * 21'(dLevel)) >>> shift;
    sum = prod + $signed({10'h000, lossLow});
    if (sum < 0)
      estimate = 11'h000;
    else if (sum > 21'sh0007FF)
      estimate = 11'h7FF;
    else
      estimate = sum[10:0];
  end
endmodule : atl_interp

// *** atl_ctrl.sv ***
`timescale 1ns/100ps
// Function
// - five-bit base level sets first learn current
// - increment code selects 128, 16, 32, 64
// - dwell code selects 8/16/24/32 half-cycles
// - go bit starts learning, self-clears when done
// - complete flag set when learning finishes
// - initial level dwell, then final level dwell
// - store eleven-bit losses at both levels
// - after learning, current goes to ceiling
// - compensation rescales band limits and fixed loss
// - eight-bit upper and lower band limits
// - applied current readable, kept within limits outside learning
// - above flag when metric exceeds upper
// - below flag when metric under lower
// - raise current above band, lower below
// - initial is base times eight, final adds increment
// - enable bit turns adaptive torque on
// - interpolate fixed loss between learned constants
module atl_ctrl #(
  parameter int CurStep = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cken,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic halfCycleTick,
  input wire logic [7:0] loadPowerMetric,
  input wire logic [10:0] fixedLossMetric,
  input wire logic [7:0] supplyRatio,
  output logic [7:0] appliedCurrent,
  output logic [10:0] lossEstimate,
  output logic learnActive
);

  if (CurStep < 1 || CurStep > 255)
  begin : gCheck
    $error("CurStep must lie in 1..255");
  end

  localparam logic [8:0] STEP9 = 9'(CurStep);

  logic enable_q;
  logic comp_q;
  logic learnGo_q;
  logic learnDone_q;
  logic [4:0] base_q;
  logic [1:0] inc_q;
  logic [1:0] dwellSel_q;
  logic [10:0] lossLow_q;
  logic [10:0] lossHigh_q;
  logic [7:0] upper_q;
  logic [7:0] lower_q;
  logic [7:0] floor_q;
  logic [7:0] ceil_q;
  logic [7:0] curr_q;
  logic above_q;
  logic below_q;
  logic [10:0] lossEst_q;
  atl_pkg::atl_state_e state_q;
  logic [5:0] hcCnt_q;
  logic [5:0] dwell_q;
  logic wrPend_q;
  logic rdPend_q;
  logic [7:0] addr_q;
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic hresp_q;

  logic accept;
  logic wrEn;
  logic [31:0] rdData;
  logic [7:0] initLevel;
  logic [8:0] finalSum;
  logic [7:0] finalLevel;
  logic dwellEnd;
  logic learnFinish;
  logic startLearn;
  logic [7:0] upperEff;
  logic [7:0] lowerEff;
  logic [10:0] lossInterp;
  logic [10:0] lossScaled;
  logic [8:0] currUp;
  logic [8:0] currDown;

  // bus side: writes take no wait state, reads one so that a read right after
  // a write to the same register sees the new value
  assign accept = hsel && htrans[1] && hready;
  assign wrEn = wrPend_q && hready;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPend_q <= 1'b0;
      rdPend_q <= 1'b0;
      addr_q <= 8'h00;
    end
    else if (cken)
    begin
      if (hready)
      begin
        wrPend_q <= accept && hwrite;
        rdPend_q <= accept && !hwrite;
        if (accept)
          addr_q <= {haddr[7:2], 2'b00};
      end
      else
        rdPend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
      hresp_q <= 1'b0;
    end
    else if (cken)
    begin
      hresp_q <= 1'b0;
      if (accept && !hwrite)
        hreadyout_q <= 1'b0;
      else
        hreadyout_q <= 1'b1;
      if (rdPend_q)
        hrdata_q <= rdData;
    end
  end

  // unmapped addresses read zero and ignore writes; every answer is OKAY
  always_comb
  begin
    rdData = 32'h0000_0000;
    unique case (addr_q)
      atl_pkg::ADDR_CTRL:
      begin
        rdData[atl_pkg::CTRL_EN_BIT] = enable_q;
        rdData[atl_pkg::CTRL_COMP_BIT] = comp_q;
        rdData[atl_pkg::CTRL_GO_BIT] = learnGo_q;
      end
      atl_pkg::ADDR_LCFG:
      begin
        rdData[atl_pkg::LCFG_BASE_LSB +: 5] = base_q;
        rdData[atl_pkg::LCFG_INC_LSB +: 2] = inc_q;
        rdData[atl_pkg::LCFG_DWELL_LSB +: 2] = dwellSel_q;
      end
      atl_pkg::ADDR_LCONST:
      begin
        rdData[10:0] = lossLow_q;
        rdData[atl_pkg::LCONST_HIGH_LSB +: 11] = lossHigh_q;
      end
      atl_pkg::ADDR_BAND:
      begin
        rdData[7:0] = upper_q;
        rdData[atl_pkg::BAND_LOWER_LSB +: 8] = lower_q;
      end
      atl_pkg::ADDR_LIMIT:
      begin
        rdData[7:0] = floor_q;
        rdData[atl_pkg::LIMIT_CEIL_LSB +: 8] = ceil_q;
      end
      atl_pkg::ADDR_STAT:
      begin
        rdData[7:0] = curr_q;
        rdData[atl_pkg::STAT_ABOVE_BIT] = above_q;
        rdData[atl_pkg::STAT_BELOW_BIT] = below_q;
        rdData[atl_pkg::STAT_DONE_BIT] = learnDone_q;
        rdData[atl_pkg::STAT_BUSY_BIT] = (state_q != atl_pkg::ATL_IDLE);
      end
      default: rdData = 32'h0000_0000;
    endcase
  end

  // control and configuration registers
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      enable_q <= 1'b0;
      comp_q <= 1'b0;
      base_q <= atl_pkg::RST_BASE;
      inc_q <= atl_pkg::RST_INC;
      dwellSel_q <= atl_pkg::RST_DWELL;
      upper_q <= atl_pkg::RST_UPPER;
      lower_q <= atl_pkg::RST_LOWER;
      floor_q <= atl_pkg::RST_FLOOR;
      ceil_q <= atl_pkg::RST_CEILING;
    end
    else if (cken && wrEn)
    begin
      unique case (addr_q)
        atl_pkg::ADDR_CTRL:
        begin
          enable_q <= hwdata[atl_pkg::CTRL_EN_BIT];
          comp_q <= hwdata[atl_pkg::CTRL_COMP_BIT];
        end
        atl_pkg::ADDR_LCFG:
        begin
          base_q <= hwdata[atl_pkg::LCFG_BASE_LSB +: 5];
          inc_q <= hwdata[atl_pkg::LCFG_INC_LSB +: 2];
          dwellSel_q <= hwdata[atl_pkg::LCFG_DWELL_LSB +: 2];
        end
        atl_pkg::ADDR_BAND:
        begin
          upper_q <= hwdata[7:0];
          lower_q <= hwdata[atl_pkg::BAND_LOWER_LSB +: 8];
        end
        atl_pkg::ADDR_LIMIT:
        begin
          floor_q <= hwdata[7:0];
          ceil_q <= hwdata[atl_pkg::LIMIT_CEIL_LSB +: 8];
        end
        default:
        begin
        end
      endcase
    end
  end

  // learn levels; a final level past 255 is the caller's fault, clipped here
  assign initLevel = {base_q, 3'b000};
  assign finalSum = {1'b0, initLevel} + (9'h001 << atl_pkg::incShift(inc_q));
  assign finalLevel = finalSum[8] ? 8'hFF : finalSum[7:0];

  assign dwellEnd = halfCycleTick && (hcCnt_q == dwell_q - 6'h01);
  assign learnFinish = (state_q == atl_pkg::ATL_LEARN_HIGH) && dwellEnd;
  assign startLearn = (state_q == atl_pkg::ATL_IDLE) && learnGo_q && enable_q;

  // go is write-one-to-set; a go written while disabled is dropped
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      learnGo_q <= 1'b0;
    else if (cken)
    begin
      if (learnFinish || (!enable_q && state_q == atl_pkg::ATL_IDLE))
        learnGo_q <= 1'b0;
      else if (wrEn && addr_q == atl_pkg::ADDR_CTRL && hwdata[atl_pkg::CTRL_GO_BIT]
               && hwdata[atl_pkg::CTRL_EN_BIT])
        learnGo_q <= 1'b1;
    end
  end

  // complete flag: finish always wins, a new start clears it
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      learnDone_q <= 1'b0;
    else if (cken)
    begin
      if (learnFinish)
        learnDone_q <= 1'b1;
      else if (startLearn)
        learnDone_q <= 1'b0;
    end
  end

  // learning sequencer; dwell is frozen at start so a rewrite cannot cut it short
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= atl_pkg::ATL_IDLE;
      hcCnt_q <= 6'h00;
      dwell_q <= 6'h08;
    end
    else if (cken)
    begin
      unique case (state_q)
        atl_pkg::ATL_IDLE:
        begin
          hcCnt_q <= 6'h00;
          if (startLearn)
          begin
            dwell_q <= atl_pkg::dwellCount(dwellSel_q);
            state_q <= atl_pkg::ATL_LEARN_LOW;
          end
        end
        atl_pkg::ATL_LEARN_LOW:
        begin
          if (!enable_q)
            state_q <= atl_pkg::ATL_IDLE;
          else if (dwellEnd)
          begin
            hcCnt_q <= 6'h00;
            state_q <= atl_pkg::ATL_LEARN_HIGH;
          end
          else if (halfCycleTick)
            hcCnt_q <= hcCnt_q + 6'h01;
        end
        atl_pkg::ATL_LEARN_HIGH:
        begin
          if (!enable_q || dwellEnd)
          begin
            hcCnt_q <= 6'h00;
            state_q <= atl_pkg::ATL_IDLE;
          end
          else if (halfCycleTick)
            hcCnt_q <= hcCnt_q + 6'h01;
        end
        default: state_q <= atl_pkg::ATL_IDLE;
      endcase
    end
  end

  // learned constants: the sample of the last half-cycle at each level;
  // a capture beats a software write landing in the same cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lossLow_q <= atl_pkg::RST_LOSS;
      lossHigh_q <= atl_pkg::RST_LOSS;
    end
    else if (cken)
    begin
      if (state_q == atl_pkg::ATL_LEARN_LOW && dwellEnd && enable_q)
        lossLow_q <= fixedLossMetric;
      else if (wrEn && addr_q == atl_pkg::ADDR_LCONST)
        lossLow_q <= hwdata[10:0];
      if (learnFinish && enable_q)
        lossHigh_q <= fixedLossMetric;
      else if (wrEn && addr_q == atl_pkg::ADDR_LCONST)
        lossHigh_q <= hwdata[atl_pkg::LCONST_HIGH_LSB +: 11];
    end
  end

  atl_scale #(
    .W(8)
  ) uScaleUpper (
    .value(upper_q),
    .ratio(supplyRatio),
    .enable(comp_q),
    .scaled(upperEff)
  );

  atl_scale #(
    .W(8)
  ) uScaleLower (
    .value(lower_q),
    .ratio(supplyRatio),
    .enable(comp_q),
    .scaled(lowerEff)
  );

  atl_interp uInterp (
    .lossLow(lossLow_q),
    .lossHigh(lossHigh_q),
    .level(curr_q),
    .initLevel(initLevel),
    .shift(atl_pkg::incShift(inc_q)),
    .estimate(lossInterp)
  );

  atl_scale #(
    .W(11)
  ) uScaleLoss (
    .value(lossInterp),
    .ratio(supplyRatio),
    .enable(comp_q),
    .scaled(lossScaled)
  );

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      lossEst_q <= atl_pkg::RST_LOSS;
    else if (cken)
      lossEst_q <= lossScaled;
  end

  // band flags follow the metric, sampled once per half-cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      above_q <= 1'b0;
      below_q <= 1'b0;
    end
    else if (cken)
    begin
      if (!enable_q)
      begin
        above_q <= 1'b0;
        below_q <= 1'b0;
      end
      else if (halfCycleTick)
      begin
        above_q <= loadPowerMetric > upperEff;
        below_q <= loadPowerMetric < lowerEff;
      end
    end
  end

  assign currUp = {1'b0, curr_q} + STEP9;
  assign currDown = {1'b0, curr_q} - STEP9;

  // applied current; the regulator moves one step per half-cycle so the loop
  // cannot jump across the band in one go
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      curr_q <= atl_pkg::RST_CEILING;
    else if (cken)
    begin
      if (!enable_q)
        curr_q <= ceil_q;
      else if (learnFinish)
        curr_q <= ceil_q;
      else if (state_q == atl_pkg::ATL_LEARN_LOW)
        curr_q <= initLevel;
      else if (state_q == atl_pkg::ATL_LEARN_HIGH)
        curr_q <= finalLevel;
      else if (curr_q > ceil_q)
        curr_q <= ceil_q;
      else if (curr_q < floor_q)
        curr_q <= floor_q;
      else if (halfCycleTick && loadPowerMetric > upperEff)
      begin
        if (currUp[8] || currUp[7:0] > ceil_q)
          curr_q <= ceil_q;
        else
          curr_q <= currUp[7:0];
      end
      else if (halfCycleTick && loadPowerMetric < lowerEff)
      begin
        if (currDown[8] || currDown[7:0] < floor_q)
          curr_q <= floor_q;
        else
          curr_q <= currDown[7:0];
      end
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = hresp_q;
  assign appliedCurrent = curr_q;
  assign lossEstimate = lossEst_q;
  // low state bit is set in both learn states, so the output is a plain flop bit
  assign learnActive = state_q[0];

endmodule : atl_ctrl

// *** atl_ctrl_properties.sv ***
`timescale 1ns/100ps
module atl_ctrl_chk #(
  parameter int CurStep = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic cken,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic halfCycleTick,
  input wire logic [7:0] loadPowerMetric,
  input wire logic [7:0] appliedCurrent,
  input wire logic learnActive
);
  // shadow copies of the control, config, band and limit registers, rebuilt from bus writes
  logic wrPend_q;
  logic [7:0] wrAddr_q;
  logic [31:0] ctl_q;
  logic [31:0] cfg_q;
  logic [31:0] band_q;
  logic [31:0] lim_q;
  logic [1:0] quiet_q;
  logic [6:0] tickCnt_q;
  wire [5:0] dwell = {1'b0, cfg_q[17:16], 3'h0} + 6'h08;
  wire [8:0] incV = (cfg_q[9:8] == 2'h0) ? 9'h080 : 9'h008 << cfg_q[9:8];
  wire [8:0] sum = {1'b0, cfg_q[4:0], 3'h0} + incV;
  wire [7:0] fin = sum[8] ? 8'hFF : sum[7:0];
  wire [7:0] curFloor = lim_q[7:0];
  wire [7:0] curCeil = lim_q[15:8];
  wire tk = halfCycleTick && cken && ctl_q[0] && !ctl_q[1] && !learnActive && quiet_q == 2'h3;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      ctl_q <= 32'h0;
      cfg_q <= 32'h0;
      band_q <= 32'h0;
      lim_q <= 32'h0000FF00;
    end
    else if (hready && cken)
    begin
      wrPend_q <= hsel && htrans[1] && hwrite;
      wrAddr_q <= haddr[7:0];
      if (wrPend_q)
        case (wrAddr_q)
          atl_pkg::ADDR_CTRL: ctl_q <= hwdata;
          atl_pkg::ADDR_LCFG: cfg_q <= hwdata;
          atl_pkg::ADDR_BAND: band_q <= hwdata;
          atl_pkg::ADDR_LIMIT: lim_q <= hwdata;
          default: ;
        endcase
    end
  end

  // clamping lags a limit write by a cycle, so checks wait until writes settle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      quiet_q <= 2'h0;
    else if (wrPend_q && hready)
      quiet_q <= 2'h0;
    else if (quiet_q != 2'h3)
      quiet_q <= quiet_q + 2'h1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      tickCnt_q <= 7'h00;
    else if (!learnActive)
      tickCnt_q <= 7'h00;
    else if (halfCycleTick && cken)
      tickCnt_q <= tickCnt_q + 7'h01;
  end

  a_read_wait: assert property (hsel && htrans[1] && hready && cken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_cur_bounds: assert property (!learnActive && quiet_q == 2'h3 && curFloor <= curCeil
    |-> appliedCurrent >= curFloor && appliedCurrent <= curCeil) else $error("current outside limits");
  a_off_ceiling: assert property (!ctl_q[0] && !learnActive && quiet_q == 2'h3 |-> appliedCurrent == curCeil)
    else $error("disabled current not at ceiling");
  a_learn_init: assert property ($rose(learnActive) |=> appliedCurrent == {cfg_q[4:0], 3'h0})
    else $error("initial learn level wrong");
  a_learn_final: assert property (learnActive && halfCycleTick && cken && tickCnt_q == {1'b0, dwell - 6'h01}
    |=> ##1 appliedCurrent == fin) else $error("final learn level wrong");
  a_learn_finish: assert property ($fell(learnActive) && ctl_q[0]
    |-> tickCnt_q == {dwell, 1'b0} && appliedCurrent == curCeil) else $error("learn end wrong");
  a_step_up: assert property (tk && loadPowerMetric > band_q[7:0] && appliedCurrent >= curFloor
    && {1'b0, appliedCurrent} + 9'(CurStep) <= {1'b0, curCeil}
    |=> appliedCurrent == $past(appliedCurrent) + 8'(CurStep)) else $error("current not raised");
  a_step_down: assert property (tk && loadPowerMetric < band_q[15:8] && appliedCurrent <= curCeil
    && {1'b0, appliedCurrent} >= {1'b0, curFloor} + 9'(CurStep)
    |=> appliedCurrent == $past(appliedCurrent) - 8'(CurStep)) else $error("current not lowered");

  c_learn_done: cover property ($fell(learnActive) && ctl_q[0]);
  c_step_up: cover property (tk && loadPowerMetric > band_q[7:0]);
  c_step_down: cover property (tk && loadPowerMetric < band_q[15:8]);
endmodule : atl_ctrl_chk

bind atl_ctrl atl_ctrl_chk #(.CurStep(CurStep)) u_atl_ctrl_chk (.clk(clk), .rstn(rstn), .cken(cken), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .halfCycleTick(halfCycleTick), .loadPowerMetric(loadPowerMetric), .appliedCurrent(appliedCurrent),
  .learnActive(learnActive));

// *** atl_ctrl_tb.sv ***
`timescale 1ns/100ps
module atl_ctrl_tb;
  localparam int Step = 4;
  localparam int Limit = 20000;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic cken = 1'b1;
  logic halfCycleTick = 1'b0;
  logic [7:0] loadPowerMetric = 8'h00;
  logic [10:0] fixedLossMetric = 11'h000;
  logic [7:0] supplyRatio = 8'h80;
  logic [7:0] appliedCurrent;
  logic [10:0] lossEstimate;
  logic learnActive;
  logic [31:0] q;
  int fails = 0;
  int nTests = 0;
  int cyc = 0;
  logic [7:0] accA [5] = '{8'h04, 8'h08, 8'h0C, 8'h14, 8'h18};
  logic [31:0] accE [5] = '{32'h0003031F, 32'h07FF07FF, 32'h0000FFFF, 32'h000000FF, 32'h0};
  logic [31:0] rstE [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0000FF00, 32'h000000FF, 32'h0};
  logic [4:0] base [4] = '{5'h0A, 5'h18, 5'h18, 5'h0A};
  logic [7:0] incV [4] = '{8'h80, 8'h10, 8'h20, 8'h40};
  logic [7:0] rgM [7] = '{8'h05, 8'h05, 8'h30, 8'h20, 8'h10, 8'h18, 8'h30};
  int rgN [7] = '{3, 20, 2, 1, 1, 1, 20};
  logic [31:0] rgE [7] = '{32'h274, 32'h240, 32'h148, 32'h048, 32'h048, 32'h048, 32'h180};

  always #4 clk = ~clk;

  atl_ctrl #(.CurStep(Step)) u_atl_ctrl (.clk(clk), .rstn(rstn), .cken(cken), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .halfCycleTick(halfCycleTick), .loadPowerMetric(loadPowerMetric),
    .fixedLossMetric(fixedLossMetric), .supplyRatio(supplyRatio), .appliedCurrent(appliedCurrent),
    .lossEstimate(lossEstimate), .learnActive(learnActive));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // one single word transfer; waits on the slave, never on a fixed count
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, q & m, e);
    chk("response", {31'h0, hresp}, 32'h0);
  endtask : rdc

  task automatic tick(input int n, input logic [7:0] m, input logic [10:0] l);
    repeat (n)
    begin
      @(posedge clk);
      halfCycleTick <= 1'b1;
      loadPowerMetric <= m;
      fixedLossMetric <= l;
      @(posedge clk);
      halfCycleTick <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask : tick

  task automatic close_out;
    $display("checks %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == Limit)
    begin
      fails++;
      close_out();
    end
  end

  initial
  begin
    logic [7:0] init;
    logic [7:0] fin;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 7; i++)
      rdc("reset value", 8'(i * 4), 32'hFFFFFFFF, rstE[i]);
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'b1, accA[i], 32'hFFFFFFFF);
      rdc("field widths", accA[i], 32'hFFFFFFFF, accE[i]);
    end
    $display("test access done");
    for (int i = 0; i < 4; i++)
    begin
      init = {base[i], 3'h0};
      fin = init + incV[i];
      xfer(1'b1, atl_pkg::ADDR_LIMIT, 32'h0000F000);
      xfer(1'b1, atl_pkg::ADDR_CTRL, 32'h1);
      xfer(1'b1, atl_pkg::ADDR_LCFG, {14'h0, 2'(i), 6'h0, 2'(i), 3'h0, base[i]});
      xfer(1'b1, atl_pkg::ADDR_CTRL, 32'h5);
      rdc("learn start", atl_pkg::ADDR_STAT, 32'hCFF, 32'h800 | init);
      chk("learn active", {31'h0, learnActive}, 32'h1);
      tick((i + 1) * 8, 8'h00, 11'h100 + 11'(i));
      rdc("learn second", atl_pkg::ADDR_STAT, 32'hCFF, 32'h800 | fin);
      tick((i + 1) * 8, 8'h00, 11'h200 + 11'(i));
      rdc("go cleared", atl_pkg::ADDR_CTRL, 32'hFFFFFFFF, 32'h1);
      rdc("learn done", atl_pkg::ADDR_STAT, 32'hCFF, 32'h4F0);
      chk("learn idle", {31'h0, learnActive}, 32'h0);
      rdc("learned", atl_pkg::ADDR_LCONST, 32'hFFFFFFFF, {5'h0, 11'h200 + 11'(i), 5'h0, 11'h100 + 11'(i)});
    end
    $display("test learning done");
    xfer(1'b1, atl_pkg::ADDR_LIMIT, 32'h00008040);
    rdc("clamp ceiling", atl_pkg::ADDR_STAT, 32'hFF, 32'h80);
    xfer(1'b1, atl_pkg::ADDR_BAND, 32'h00001020);
    for (int i = 0; i < 7; i++)
    begin
      tick(rgN[i], rgM[i], 11'h0);
      rdc("regulate", atl_pkg::ADDR_STAT, 32'h3FF, rgE[i]);
    end
    // a low clock enable must hold current and flags through below-band ticks
    cken <= 1'b0;
    tick(2, 8'h05, 11'h0);
    cken <= 1'b1;
    rdc("frozen", atl_pkg::ADDR_STAT, 32'h3FF, 32'h180);
    xfer(1'b1, atl_pkg::ADDR_LIMIT, 32'h00006050);
    rdc("clamp limits", atl_pkg::ADDR_STAT, 32'hFF, 32'h60);
    xfer(1'b1, atl_pkg::ADDR_CTRL, 32'h0);
    tick(1, 8'h30, 11'h0);
    rdc("disabled", atl_pkg::ADDR_STAT, 32'h3FF, 32'h060);
    $display("test regulation done");
    xfer(1'b1, atl_pkg::ADDR_LCFG, 32'h00000308);
    xfer(1'b1, atl_pkg::ADDR_LCONST, 32'h02000100);
    xfer(1'b1, atl_pkg::ADDR_LIMIT, 32'h00006060);
    xfer(1'b1, atl_pkg::ADDR_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    chk("loss estimate", {21'h0, lossEstimate}, 32'h180);
    supplyRatio <= 8'h40;
    xfer(1'b1, atl_pkg::ADDR_CTRL, 32'h3);
    repeat (3) @(posedge clk);
    chk("scaled estimate", {21'h0, lossEstimate}, 32'h0C0);
    tick(1, 8'h14, 11'h0);
    rdc("scaled band", atl_pkg::ADDR_STAT, 32'h3FF, 32'h160);
    $display("test compensation done");
    close_out();
  end
endmodule : atl_ctrl_tb
